// *** counter_array_consts.svh ***
// Offsets, field positions, reset values and timing counts of the counter array.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

`define CA_CLK_HZ 40000000
`define CA_DIV_SLOW 12
`define CA_DIV_FAST 4
`define CA_DIV_XOSC 8

`define CA_OFF_CNT_LO 8'h00
`define CA_OFF_CNT_HI 8'h04
`define CA_OFF_MODE 8'h08
`define CA_OFF_CTRL 8'h0c
`define CA_OFF_MOD_BASE 8'h10
`define CA_MOD_STRIDE 8'h10
`define CA_MOD_MODE 8'h00
`define CA_MOD_LO 8'h04
`define CA_MOD_HI 8'h08

`define CA_MD_OVF_IE 0
`define CA_MD_TB_LSB 1
`define CA_MD_IDLE 7
`define CA_MD_OVF 8

`define CA_CN_RUN 6
`define CA_CN_IRQ_EN 7
`define CA_CN_GIE 8

`define CA_CM_IRQ 0
`define CA_CM_PWM 1
`define CA_CM_TOG 2
`define CA_CM_MAT 3
`define CA_CM_FALL 4
`define CA_CM_RISE 5
`define CA_CM_COMP 6
`define CA_CM_WIDE 7

`define CA_MODE_RST 8'h00
`define CA_MD_RST 9'h000
`endif

// *** counter_array_pkg.sv ***
// Types of the counter array.
// Assumes counter_array_consts.svh supplies the numbers.
`default_nettype none
package counter_array_pkg;

   typedef enum logic [2:0] {
      TB_DIV12 = 3'h0,
      TB_DIV4 = 3'h1,
      TB_T0 = 3'h2,
      TB_EXT = 3'h3,
      TB_SYS = 3'h4,
      TB_XOSC = 3'h5
   } timebase_t;

   typedef enum logic [5:0] {
      M_OFF = 6'h01,
      M_CAPTURE = 6'h02,
      M_SWTIMER = 6'h04,
      M_HSOUT = 6'h08,
      M_FREQ = 6'h10,
      M_PWM = 6'h20
   } module_mode_t;

   typedef struct packed {
      logic wide_pulse_select;
      logic comparator_enable;
      logic rising_capture_enable;
      logic falling_capture_enable;
      logic compare_hit_enable;
      logic output_flip_enable;
      logic pulse_enable;
      logic module_irq_enable;
   } mode_bits_t;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
   } wb_req_t;

endpackage : counter_array_pkg
`default_nettype wire

// *** counter_array.sv ***
// Counter array: 16-bit counter, selectable timebase, three capture/compare
// modules, reached as a classic Wishbone slave with one-cycle ack.
// Assumes pins are asynchronous and are synchronised here; single clock.
//
// Behaviour
// - One 16-bit counter made of low and high byte registers.
// - Reading low byte latches high byte; next high read returns latch.
// - Three independent 16-bit capture/compare modules, each with one line.
// - Timebase field picks clk/12, clk/4, timer0, ext falls, clk, osc/8.
// - External count advances on falls; source must stay below clk/4.
// - Counter wrap from all ones to zero sets the overflow flag.
// - Overflow enable lets flag request interrupt; software clears flag.
// - Interrupts reach the CPU only with global and array enables set.
// - With idle suspend clear, the array runs during CPU idle.
// - Capture mode picks rising, falling or both edges by two bits.
// - Valid capture edge loads the counter into the module register.
// - A capture sets the module flag and may request an interrupt.
// - Module flag stays set until software clears it.
// - Software can read the current level of each module line.
// - Each module has its own interrupt enable bit.
// - Software timer mode compares counter against module register.
// - Software timer match sets module flag and may interrupt.
// - High-speed output inverts module line on every match.
// - Frequency and 8/16-bit pulse mode encodings are decoded.
// - Low byte write clears comparator enable; high byte write sets it.
// - Six timebases and six per-module modes, selected independently.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_consts.svh"

module counter_array #(
   parameter int NUM_MODULES = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic cpu_idle_i,
   input wire logic timer0_overflow_i,
   input wire logic external_count_input_i,
   input wire logic external_osc_i,
   input wire logic [NUM_MODULES-1:0] module_io_line_i,
   output logic [NUM_MODULES-1:0] module_io_line_o,
   output logic [NUM_MODULES-1:0] module_io_line_oe_o,
   output logic irq_o
);

   if (NUM_MODULES < 1 || NUM_MODULES > 3) begin : g_bad_count
      $error("NUM_MODULES must be 1 to 3");
   end
   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic counter_array_pkg::module_mode_t
         decode_mode(input counter_array_pkg::mode_bits_t m);
      counter_array_pkg::module_mode_t r;
      r = counter_array_pkg::M_OFF;
      if (!m.compare_hit_enable && !m.output_flip_enable && !m.pulse_enable
          && (m.rising_capture_enable || m.falling_capture_enable)) begin
         r = counter_array_pkg::M_CAPTURE;
      end else if (m.comparator_enable && !m.rising_capture_enable
                   && !m.falling_capture_enable) begin
         if (m.output_flip_enable && m.pulse_enable) begin
            r = counter_array_pkg::M_FREQ;
         end else if (m.pulse_enable && !m.output_flip_enable) begin
            r = counter_array_pkg::M_PWM;
         end else if (m.compare_hit_enable && m.output_flip_enable) begin
            r = counter_array_pkg::M_HSOUT;
         end else if (m.compare_hit_enable) begin
            r = counter_array_pkg::M_SWTIMER;
         end
      end
      return r;
   endfunction : decode_mode
   function automatic logic [7:0] mod_off(input int idx, input logic [7:0] f);
      return 8'(`CA_OFF_MOD_BASE + 8'(idx) * `CA_MOD_STRIDE + f);
   endfunction : mod_off
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stages feed only second stages
   logic [NUM_MODULES+2:0] pin_s1_q;
   logic [NUM_MODULES+2:0] pin_s2_q;
   logic [NUM_MODULES+2:0] pin_s3_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= {external_osc_i, external_count_input_i,
                      timer0_overflow_i, module_io_line_i};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   logic [NUM_MODULES-1:0] line_now;
   logic [NUM_MODULES-1:0] line_prev;
   logic t0_rise;
   logic ext_fall;
   logic osc_rise;
   assign line_now = pin_s2_q[NUM_MODULES-1:0];
   assign line_prev = pin_s3_q[NUM_MODULES-1:0];
   assign t0_rise = pin_s2_q[NUM_MODULES] && !pin_s3_q[NUM_MODULES];
   assign ext_fall = !pin_s2_q[NUM_MODULES+1]
                     && pin_s3_q[NUM_MODULES+1];
   assign osc_rise = pin_s2_q[NUM_MODULES+2] && !pin_s3_q[NUM_MODULES+2];
   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   counter_array_pkg::wb_req_t req;
   logic bus_go;
   logic wr_go;
   logic rd_go;
   assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};
   assign bus_go = cyc_i && stb_i && !ack_o;
   assign wr_go = bus_go && req.we && req.sel[0];
   assign rd_go = bus_go && !req.we;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_go;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Array mode and control
   logic [2:0] timebase_select_q;
   logic overflow_irq_enable_q;
   logic idle_suspend_q;
   logic run_q;
   logic array_irq_enable_q;
   logic global_irq_enable_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timebase_select_q <= 3'h0;
         overflow_irq_enable_q <= 1'b0;
         idle_suspend_q <= 1'b0;
         run_q <= 1'b0;
         array_irq_enable_q <= 1'b0;
         global_irq_enable_q <= 1'b0;
      end else if (wr_go) begin
         if (req.adr == `CA_OFF_MODE) begin
            timebase_select_q <= req.dat[`CA_MD_TB_LSB +: 3];
            overflow_irq_enable_q <= req.dat[`CA_MD_OVF_IE];
            idle_suspend_q <= req.dat[`CA_MD_IDLE];
         end else if (req.adr == `CA_OFF_CTRL) begin
            run_q <= req.dat[`CA_CN_RUN];
            array_irq_enable_q <= req.dat[`CA_CN_IRQ_EN];
            global_irq_enable_q <= req.sel[1] ? req.dat[`CA_CN_GIE]
                                             : global_irq_enable_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timebase dividers
   logic [3:0] div12_q;
   logic [1:0] div4_q;
   logic [2:0] div8_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div12_q <= 4'h0;
         div4_q <= 2'h0;
         div8_q <= 3'h0;
      end else begin
         div12_q <= (div12_q == 4'(`CA_DIV_SLOW - 1)) ? 4'h0 : div12_q + 4'h1;
         div4_q <= div4_q + 2'h1;
         if (osc_rise) begin
            div8_q <= div8_q + 3'h1;
         end
      end
   end

   logic tick;
   always_comb begin
      case (counter_array_pkg::timebase_t'(timebase_select_q))
         counter_array_pkg::TB_DIV12: tick = div12_q == 4'h0;
         counter_array_pkg::TB_DIV4: tick = div4_q == 2'h0;
         counter_array_pkg::TB_T0: tick = t0_rise;
         counter_array_pkg::TB_EXT: tick = ext_fall;
         counter_array_pkg::TB_SYS: tick = 1'b1;
         counter_array_pkg::TB_XOSC: tick = osc_rise && div8_q == 3'h7;
         default: tick = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // Counter, snapshot and overflow flag
   logic [15:0] count_q;
   logic [7:0] snapshot_q;
   logic counter_overflow_flag_q;
   logic count_en;
   logic wrap;
   // Idle only pauses counting when idle_suspend is set
   assign count_en = run_q && tick && !(cpu_idle_i && idle_suspend_q);
   assign wrap = count_en && count_q == 16'hffff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= 16'h0000;
      end else if (wr_go && req.adr == `CA_OFF_CNT_LO) begin
         count_q[7:0] <= req.dat[7:0];
      end else if (wr_go && req.adr == `CA_OFF_CNT_HI) begin
         count_q[15:8] <= req.dat[7:0];
      end else if (count_en) begin
         count_q <= count_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snapshot_q <= 8'h00;
      end else if (rd_go && req.adr == `CA_OFF_CNT_LO) begin
         snapshot_q <= count_q[15:8];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_overflow_flag_q <= 1'b0;
      end else if (wrap) begin
         counter_overflow_flag_q <= 1'b1;
      end else if (wr_go && req.adr == `CA_OFF_MODE) begin
         counter_overflow_flag_q <= req.dat[`CA_MD_OVF];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Capture/compare modules
   counter_array_pkg::mode_bits_t mode_q [NUM_MODULES];
   logic [15:0] value_q [NUM_MODULES];
   logic [NUM_MODULES-1:0] module_event_flag_q;
   logic [NUM_MODULES-1:0] line_out_q;
   logic [NUM_MODULES-1:0] capture_hit;
   logic [NUM_MODULES-1:0] match_hit;
   logic [NUM_MODULES-1:0] drive_line;

   for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
      counter_array_pkg::module_mode_t mm;
      logic rise;
      logic fall;
      logic wr_mode;
      logic wr_lo;
      logic wr_hi;
      assign mm = decode_mode(mode_q[i]);
      assign rise = line_now[i] && !line_prev[i];
      assign fall = !line_now[i] && line_prev[i];
      assign capture_hit[i] = mm == counter_array_pkg::M_CAPTURE
         && ((rise && mode_q[i].rising_capture_enable)
             || (fall && mode_q[i].falling_capture_enable));
      assign match_hit[i] = count_en && count_q + 16'h0001 == value_q[i]
         && (mm == counter_array_pkg::M_SWTIMER
             || mm == counter_array_pkg::M_HSOUT);
      assign drive_line[i] = mm == counter_array_pkg::M_HSOUT;
      assign wr_mode = wr_go && req.adr == mod_off(i, `CA_MOD_MODE);
      assign wr_lo = wr_go && req.adr == mod_off(i, `CA_MOD_LO);
      assign wr_hi = wr_go && req.adr == mod_off(i, `CA_MOD_HI);
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mode_q[i] <= counter_array_pkg::mode_bits_t'(`CA_MODE_RST);
         end else if (wr_mode) begin
            mode_q[i] <= counter_array_pkg::mode_bits_t'(req.dat[7:0]);
         end else if (wr_lo) begin
            mode_q[i].comparator_enable <= 1'b0;
         end else if (wr_hi) begin
            mode_q[i].comparator_enable <= 1'b1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            value_q[i] <= 16'h0000;
         end else if (capture_hit[i]) begin
            value_q[i] <= count_q;
         end else if (wr_lo) begin
            value_q[i][7:0] <= req.dat[7:0];
         end else if (wr_hi) begin
            value_q[i][15:8] <= req.dat[7:0];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            module_event_flag_q[i] <= 1'b0;
         end else if (capture_hit[i] || match_hit[i]) begin
            module_event_flag_q[i] <= 1'b1;
         end else if (wr_go && req.adr == `CA_OFF_CTRL) begin
            module_event_flag_q[i] <= req.dat[i];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            line_out_q[i] <= 1'b0;
         end else if (match_hit[i] && drive_line[i]) begin
            line_out_q[i] <= !line_out_q[i];
         end
      end
   end

   assign module_io_line_o = line_out_q;
   assign module_io_line_oe_o = drive_line;
   ////////////////////////////////////////////////////////////////////////
   // Interrupt request to the CPU's interrupt system
   logic [NUM_MODULES-1:0] mod_ie;
   always_comb begin
      for (int k = 0; k < NUM_MODULES; k++) begin
         mod_ie[k] = mode_q[k].module_irq_enable;
      end
   end
   assign irq_o = global_irq_enable_q && array_irq_enable_q
      && ((counter_overflow_flag_q && overflow_irq_enable_q)
          || |(module_event_flag_q & mod_ie));
   ////////////////////////////////////////////////////////////////////////
   // Read data; unmapped addresses read zero
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      if (req.adr == `CA_OFF_CNT_LO) begin
         rd_d[7:0] = count_q[7:0];
      end else if (req.adr == `CA_OFF_CNT_HI) begin
         rd_d[7:0] = snapshot_q;
      end else if (req.adr == `CA_OFF_MODE) begin
         rd_d[`CA_MD_OVF] = counter_overflow_flag_q;
         rd_d[`CA_MD_IDLE] = idle_suspend_q;
         rd_d[`CA_MD_TB_LSB +: 3] = timebase_select_q;
         rd_d[`CA_MD_OVF_IE] = overflow_irq_enable_q;
      end else if (req.adr == `CA_OFF_CTRL) begin
         rd_d[NUM_MODULES-1:0] = module_event_flag_q;
         rd_d[`CA_CN_RUN] = run_q;
         rd_d[`CA_CN_IRQ_EN] = array_irq_enable_q;
         rd_d[`CA_CN_GIE] = global_irq_enable_q;
         rd_d[16 +: NUM_MODULES] = line_now;
      end else begin
         for (int k = 0; k < NUM_MODULES; k++) begin
            if (req.adr == mod_off(k, `CA_MOD_MODE)) begin
               rd_d[7:0] = mode_q[k];
            end else if (req.adr == mod_off(k, `CA_MOD_LO)) begin
               rd_d[7:0] = value_q[k][7:0];
            end else if (req.adr == mod_off(k, `CA_MOD_HI)) begin
               rd_d[7:0] = value_q[k][15:8];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_go) begin
         dat_o <= rd_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      wrap |=> counter_overflow_flag_q)
      else $error("overflow flag not set after wrap");
   chk_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      count_en && !wr_go |=> count_q == $past(count_q) + 16'h0001)
      else $error("counter did not advance");
   chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      cpu_idle_i && idle_suspend_q && !wr_go |=> $stable(count_q))
      else $error("counter moved while suspended");
   chk_snap_hi: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_go && req.adr == `CA_OFF_CNT_LO |=> snapshot_q == $past(count_q[15:8]))
      else $error("snapshot wrong");
   chk_cap_load: assert property (@(posedge clk_i) disable iff (rst_i)
      capture_hit[0] |=> value_q[0] == $past(count_q) && module_event_flag_q[0])
      else $error("capture not loaded");
   chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      module_event_flag_q[0] && !(wr_go && req.adr == `CA_OFF_CTRL)
      |=> module_event_flag_q[0])
      else $error("flag dropped by hardware");
   chk_lo_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_go && req.adr == mod_off(NUM_MODULES-1, `CA_MOD_LO)
      |=> !mode_q[NUM_MODULES-1].comparator_enable)
      else $error("low write kept comparator on");
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !(global_irq_enable_q && array_irq_enable_q) |-> !irq_o)
      else $error("interrupt without enables");
   chk_hs_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      match_hit[NUM_MODULES-1] && drive_line[NUM_MODULES-1]
      |=> line_out_q[NUM_MODULES-1] != $past(line_out_q[NUM_MODULES-1]))
      else $error("line did not invert");
   chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held");
   cov_capture: cover property (@(posedge clk_i) capture_hit[0]);
   cov_match: cover property (@(posedge clk_i) |match_hit);
   cov_wrap: cover property (@(posedge clk_i) wrap);
   cov_irq: cover property (@(posedge clk_i) irq_o);
endmodule : counter_array

`default_nettype wire

// *** pin_model.sv ***
// Far-side model: sources on the module lines and the count inputs.
// Assumes the bench sets wanted line levels and calls pulse().
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   input wire logic clk_i,
   input wire logic [2:0] level_i,
   input wire logic [2:0] drv_i,
   input wire logic [2:0] oe_i,
   output logic [2:0] line_o,
   output var logic t0_o,
   output var logic ext_o,
   output var logic osc_o
);
   // A line the block drives shows the block's level
   assign line_o = (oe_i & drv_i) | (~oe_i & level_i);
   initial begin
      t0_o = 1'b0;
      ext_o = 1'b1;
      osc_o = 1'b0;
   end
   // Eight clocks a pulse keeps the count source below clk/4
   task automatic pulse(input int src, input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_i);
         if (src == 0)
            t0_o <= 1'b1;
         else if (src == 1)
            ext_o <= 1'b0;
         else
            osc_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         t0_o <= 1'b0;
         ext_o <= 1'b1;
         osc_o <= 1'b0;
      end
   endtask : pulse
endmodule : pin_model
`default_nettype wire

// *** counter_array_test.sv ***
// Bench: bus tasks, row tables for timebase, capture and modes.
// Assumes pin_model on the pins and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module counter_array_test;
   typedef struct {logic [2:0] t; int s; int n; int lo; int hi;} tb_row_t;
   typedef struct {logic [7:0] m; logic l; logic f;} cap_row_t;
   typedef struct {logic [7:0] m; logic oe;} mode_row_t;
   // Clock rows carry slack for bus latency and prescaler phase
   tb_row_t tbr[6] = '{'{3'h0, -1, 120, 10, 12}, '{3'h1, -1, 120, 31, 34},
      '{3'h4, -1, 120, 127, 135}, '{3'h2, 0, 6, 6, 6},
      '{3'h3, 1, 6, 6, 6}, '{3'h5, 2, 16, 2, 2}};
   cap_row_t cr[8] = '{'{8'h21, 1, 1}, '{8'h21, 0, 0}, '{8'h11, 1, 0},
      '{8'h11, 0, 1}, '{8'h31, 1, 1}, '{8'h31, 0, 1}, '{8'h20, 1, 1},
      '{8'h00, 0, 0}};
   mode_row_t mr[7] = '{'{8'h00, 0}, '{8'h20, 0}, '{8'h48, 0},
      '{8'h46, 0}, '{8'h42, 0}, '{8'hc2, 0}, '{8'h4c, 1}};
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, idle, x;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [2:0] lvl, io_o, oe, line;
   logic t0, ext, osc;
   logic [15:0] c, v;
   int failures = 0;
   int checked = 0;
   int cyc_n = 0;
   counter_array DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cpu_idle_i(idle),
      .timer0_overflow_i(t0), .external_count_input_i(ext),
      .external_osc_i(osc), .module_io_line_i(line),
      .module_io_line_o(io_o), .module_io_line_oe_o(oe), .irq_o(irq_o));
   pin_model P (.clk_i(clk_i), .level_i(lvl), .drv_i(io_o), .oe_i(oe),
      .line_o(line), .t0_o(t0), .ext_o(ext), .osc_o(osc));
   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // Held until ack is sampled high; read data taken at that edge
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic cnt();
      wb(1'b0, 8'h00, 32'h0);
      c[7:0] = q[7:0];
      wb(1'b0, 8'h04, 32'h0);
      c[15:8] = q[7:0];
   endtask : cnt
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h0;
      idle = 1'b0;
      lvl = 3'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("oe_rst", 32'h0, {irq_o, oe});
      wb(1'b0, 8'h08, 32'h0);
      chk("mode_rst", 32'h0, q);
      wb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", 32'h0, q);
      // Idle stays high: with suspend clear the count must go on
      idle <= 1'b1;
      foreach (tbr[i]) begin
         wb(1'b1, 8'h0c, 32'h0);
         wb(1'b1, 8'h00, 32'h0);
         wb(1'b1, 8'h04, 32'h0);
         wb(1'b1, 8'h08, {28'h0, tbr[i].t, 1'b0});
         wb(1'b1, 8'h0c, 32'h40);
         if (tbr[i].s < 0)
            repeat (tbr[i].n) @(posedge clk_i);
         else
            P.pulse(tbr[i].s, tbr[i].n);
         repeat (8) @(posedge clk_i);
         wb(1'b0, 8'h00, 32'h0);
         chk("tb_count", 1, q >= tbr[i].lo && q <= tbr[i].hi);
      end
      wb(1'b1, 8'h08, 32'h08);
      wb(1'b1, 8'h00, 32'hf0);
      wb(1'b1, 8'h04, 32'h12);
      repeat (20) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0);
      v[7:0] = q[7:0];
      repeat (300) @(posedge clk_i);
      wb(1'b0, 8'h04, 32'h0);
      chk("snapshot", (v[7:0] < 8'hf0) ? 32'h13 : 32'h12, q[7:0]);
      wb(1'b1, 8'h08, 32'h09);
      wb(1'b1, 8'h00, 32'hf0);
      wb(1'b1, 8'h04, 32'hff);
      wb(1'b1, 8'h0c, 32'h1c0);
      chk("irq_pre", 32'h0, irq_o);
      repeat (30) @(posedge clk_i);
      chk("ovf_irq", 32'h1, irq_o);
      wb(1'b1, 8'h0c, 32'h0c0);
      chk("gie_off", 32'h0, irq_o);
      wb(1'b0, 8'h08, 32'h0);
      chk("ovf_flag", 32'h109, q[8:0]);
      wb(1'b1, 8'h08, 32'h08);
      wb(1'b0, 8'h08, 32'h0);
      chk("ovf_clr", 32'h008, q[8:0]);
      foreach (cr[i]) begin
         wb(1'b1, 8'h0c, 32'h1c0);
         wb(1'b1, 8'h10, cr[i].m);
         lvl[0] <= cr[i].l;
         repeat (6) @(posedge clk_i);
         wb(1'b0, 8'h0c, 32'h0);
         chk("cap_flag", cr[i].f, q[0]);
         chk("cap_irq", cr[i].f & cr[i].m[0], irq_o);
         chk("line_lvl", cr[i].l, q[16]);
      end
      wb(1'b1, 8'h10, 32'h20);
      cnt();
      lvl[0] <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(1'b0, 8'h14, 32'h0);
      v[7:0] = q[7:0];
      wb(1'b0, 8'h18, 32'h0);
      v[15:8] = q[7:0];
      chk("cap_val", 1, v > c && v < c + 16'd20);
      wb(1'b1, 8'h20, 32'h49);
      cnt();
      v = c + 16'd60;
      wb(1'b1, 8'h24, v[7:0]);
      wb(1'b0, 8'h20, 32'h0);
      chk("comp_clr", 32'h09, q[7:0]);
      wb(1'b1, 8'h28, v[15:8]);
      wb(1'b0, 8'h20, 32'h0);
      chk("comp_set", 32'h49, q[7:0]);
      wb(1'b0, 8'h0c, 32'h0);
      chk("pre_hit", 32'h0, q[1]);
      repeat (70) @(posedge clk_i);
      wb(1'b0, 8'h0c, 32'h0);
      chk("hit_flag", 32'h1, q[1]);
      foreach (mr[i]) begin
         wb(1'b1, 8'h30, mr[i].m);
         wb(1'b0, 8'h30, 32'h0);
         chk("mode_rd", mr[i].m, q[7:0]);
         chk("oe", mr[i].oe, oe[2]);
      end
      chk("oe_other", 32'h0, oe[1:0]);
      cnt();
      v = c + 16'd40;
      wb(1'b1, 8'h34, v[7:0]);
      wb(1'b1, 8'h38, v[15:8]);
      x = io_o[2];
      repeat (50) @(posedge clk_i);
      chk("hs_flip", {31'h0, ~x}, line[2]);
      // Suspend set while idle is high: the count must freeze
      wb(1'b1, 8'h08, 32'h88);
      cnt();
      v = c;
      repeat (20) @(posedge clk_i);
      cnt();
      chk("idle_hold", v, c);
      print_verdict();
   end
endmodule : counter_array_test
`default_nettype wire
